// [rtl/host_port_pkg.sv]
// Constants and types shared by the parallel host register bank.
package host_port_pkg;
  // ****************************************************************
  // Register select codes
  // ****************************************************************
  localparam logic [1:0] SEL_MESSAGE    = 2'h0;
  localparam logic [1:0] SEL_CONTROL    = 2'h1;
  localparam logic [1:0] SEL_PCM        = 2'h2;
  localparam logic [1:0] SEL_COMPRESSED = 2'h3;
  // ****************************************************************
  // Control register bit positions
  // ****************************************************************
  localparam int BIT_CMP_RST   = 6;
  localparam int BIT_PCM_RST   = 5;
  localparam int BIT_PCM_AF    = 4;
  localparam int BIT_CMP_AF    = 3;
  localparam int BIT_IN_PEND   = 2;
  localparam int BIT_OUT_WAIT  = 1;
  // ****************************************************************
  // Buffer geometry and reset values
  // ****************************************************************
  localparam int            FIFO_DEPTH   = 16;
  localparam int            LEVEL_W      = 5;
  localparam logic [4:0]    AF_THRESHOLD = 5'h0C;
  localparam logic [4:0]    LEVEL_ZERO   = 5'h00;
  localparam logic [4:0]    LEVEL_ONE    = 5'h01;
  localparam logic [3:0]    PTR_ONE      = 4'h1;
  localparam logic [7:0]    BYTE_ZERO    = 8'h00;
  localparam logic          CH_RST_INIT  = 1'b1;
  typedef enum logic [1:0] {
    ACC_IDLE  = 2'b00,
    ACC_READ  = 2'b01,
    ACC_WRITE = 2'b10
  } access_t;
endpackage

// [rtl/input_fifo_if.sv]
// Interface between the register bank and one audio input buffer.
`timescale 1ns/1ns
interface input_fifo_if;
  logic       push;
  logic [7:0] push_data;
  logic       chan_reset;
  logic       pop;
  logic [7:0] pop_data;
  logic       not_empty;
  logic       almost_full;
  modport bank (output push, push_data, chan_reset, pop,
                input pop_data, not_empty, almost_full);
  modport fifo (input push, push_data, chan_reset, pop,
                output pop_data, not_empty, almost_full);
endinterface // input_fifo_if

// [rtl/audio_input_fifo.sv]
// One audio input buffer with almost-full flag and channel reset.
`timescale 1ns/1ns
module audio_input_fifo
  import host_port_pkg::*;
(
  // Clock and control.
  input  wire logic CLOCK,
  input  wire logic RST_B,
  input  wire logic CLK_EN,
  // Bank side.
  input_fifo_if.fifo f
);
  logic [7:0]   mem [FIFO_DEPTH];
  logic [3:0]   wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [4:0]   level, next_level;
  logic         do_push, do_pop;

  always_comb begin
    do_push     = f.push && !f.chan_reset && (level != 5'(FIFO_DEPTH));
    do_pop      = f.pop && !f.chan_reset && (level != LEVEL_ZERO);
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_level  = level;
    if (f.chan_reset) begin
      // [RQ19] reset empties buffer
      next_wr_ptr = 4'h0;
      next_rd_ptr = 4'h0;
      next_level  = LEVEL_ZERO;
    end else begin
      if (do_push) next_wr_ptr = wr_ptr + PTR_ONE;
      if (do_pop) next_rd_ptr = rd_ptr + PTR_ONE;
      if (do_push && !do_pop) next_level = level + LEVEL_ONE;
      if (do_pop && !do_push) next_level = level - LEVEL_ONE;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      level  <= LEVEL_ZERO;
    end else if (CLK_EN) begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      level  <= next_level;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (CLK_EN && do_push) mem[wr_ptr] <= f.push_data;
  end

  assign f.pop_data    = mem[rd_ptr];
  assign f.not_empty   = (level != LEVEL_ZERO);
  // [RQ15] threshold almost full
  assign f.almost_full = (level >= AF_THRESHOLD);
endmodule // audio_input_fifo

// [rtl/parallel_host_register_bank.sv]
// Parallel host port register bank: message, control and audio input registers.
// Functional notes
// [RQ1] Message register at select 00 has separate inbound and outbound bytes.
// [RQ2] Host read or write of message register updates handshake flags.
// [RQ3] Host writes zero to reserved control bits 7 and 0.
// [RQ4] Control bit 6 holds compressed channel in reset while one.
// [RQ5] Control bit 5 holds PCM channel in reset while one.
// [RQ6] Host keeps both channel reset bits low in normal operation.
// [RQ7] Control bit 4 reads high while PCM buffer almost full.
// [RQ8] Control bit 3 reads high while compressed buffer almost full.
// [RQ9] Bit 2 set by host message write, cleared by core read.
// [RQ10] Host checks inbound pending before writing the next message byte.
// [RQ11] Bit 1 set by core message write, cleared by host read.
// [RQ12] Core checks outbound waiting before writing another outbound byte.
// [RQ13] Host write to select 10 pushes byte into PCM buffer.
// [RQ14] Host write to select 11 pushes byte into compressed buffer.
// [RQ15] Almost-full flags assert when buffer level reaches threshold.
// [RQ16] Attention request output mirrors the outbound waiting flag.
// [RQ17] Host reads only message and control registers.
// [RQ18] Writes to read-only flags ignored; reset bits read as zero.
// [RQ19] Channel in reset empties buffer, clears flag, drops writes.
`timescale 1ns/1ns
module parallel_host_register_bank
  import host_port_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic       CLOCK,
  input  wire logic       RST_B,
  input  wire logic       CLK_EN,
  // Host strobes, one-cycle pulses taken at CLOCK.
  input  wire logic [1:0] HOST_ADDR,
  input  wire logic       HOST_RD,
  input  wire logic       HOST_WR,
  input  wire logic [7:0] HOST_WDATA,
  output logic      [7:0] HOST_RDATA,
  output logic            HOST_DATA_OE,
  output logic            HOST_ATTENTION_REQUEST,
  // Decoder core message side.
  input  wire logic       CORE_MSG_RD,
  input  wire logic       CORE_MSG_WR,
  input  wire logic [7:0] CORE_MSG_WDATA,
  output logic      [7:0] CORE_MSG_RDATA,
  output logic            CORE_INBOUND_PENDING,
  output logic            CORE_OUTBOUND_WAITING,
  // Decoder core audio buffer side.
  input  wire logic       PCM_POP,
  input  wire logic       CMP_POP,
  output logic      [7:0] PCM_BYTE,
  output logic            PCM_VALID,
  output logic      [7:0] CMP_BYTE,
  output logic            CMP_VALID,
  output logic            PCM_CHANNEL_RESET,
  output logic            CMP_CHANNEL_RESET
);
  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0] inbound_byte, next_inbound_byte;
  logic [7:0] outbound_byte, next_outbound_byte;
  logic       inbound_pending, next_inbound_pending;
  logic       outbound_waiting, next_outbound_waiting;
  logic       pcm_channel_reset, next_pcm_channel_reset;
  logic       compressed_channel_reset, next_compressed_channel_reset;
  logic [7:0] rdata, next_rdata;
  logic       data_oe, next_data_oe;
  access_t    access;
  logic       host_rd_msg, host_wr_msg, host_wr_ctl, core_wr_ok;

  input_fifo_if pcm_if ();
  input_fifo_if cmp_if ();

  function automatic logic [7:0] control_image(input logic pcm_af, input logic cmp_af,
                                               input logic in_p, input logic out_w);
    logic [7:0] v;
    v = BYTE_ZERO;
    v[BIT_PCM_AF]   = pcm_af;
    v[BIT_CMP_AF]   = cmp_af;
    v[BIT_IN_PEND]  = in_p;
    v[BIT_OUT_WAIT] = out_w;
    return v;
  endfunction

  // ****************************************************************
  // Access decode and next-state logic
  // ****************************************************************
  always_comb begin
    access = HOST_WR ? ACC_WRITE : (HOST_RD ? ACC_READ : ACC_IDLE);
    host_rd_msg = (access == ACC_READ) && (HOST_ADDR == SEL_MESSAGE);
    host_wr_msg = (access == ACC_WRITE) && (HOST_ADDR == SEL_MESSAGE);
    host_wr_ctl = (access == ACC_WRITE) && (HOST_ADDR == SEL_CONTROL);
    // [RQ12] core writes only when free
    core_wr_ok  = CORE_MSG_WR && !outbound_waiting;
    next_inbound_byte             = inbound_byte;
    next_outbound_byte            = outbound_byte;
    next_inbound_pending          = inbound_pending;
    next_outbound_waiting         = outbound_waiting;
    next_pcm_channel_reset        = pcm_channel_reset;
    next_compressed_channel_reset = compressed_channel_reset;
    next_rdata                    = rdata;
    next_data_oe                  = 1'b0;
    // [RQ1] separate inbound byte
    if (host_wr_msg) next_inbound_byte = HOST_WDATA;
    if (core_wr_ok) next_outbound_byte = CORE_MSG_WDATA;
    // [RQ2] message access moves flags
    // [RQ9] inbound pending, set wins
    if (CORE_MSG_RD) next_inbound_pending = 1'b0;
    if (host_wr_msg) next_inbound_pending = 1'b1;
    // [RQ11] outbound waiting, set wins
    if (host_rd_msg) next_outbound_waiting = 1'b0;
    if (core_wr_ok) next_outbound_waiting = 1'b1;
    // [RQ4] [RQ5] reset bits; [RQ18] flag bits ignored
    if (host_wr_ctl) begin
      next_compressed_channel_reset = HOST_WDATA[BIT_CMP_RST];
      next_pcm_channel_reset        = HOST_WDATA[BIT_PCM_RST];
    end
    if (access == ACC_READ) begin
      next_data_oe = 1'b1;
      case (HOST_ADDR)
        SEL_MESSAGE: next_rdata = outbound_byte;
        // [RQ7] [RQ8] flags shown; [RQ18] reset bits read zero
        SEL_CONTROL: next_rdata = control_image(pcm_if.almost_full, cmp_if.almost_full,
                                                inbound_pending, outbound_waiting);
        default:     next_rdata = BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      inbound_byte             <= BYTE_ZERO;
      outbound_byte            <= BYTE_ZERO;
      inbound_pending          <= 1'b0;
      outbound_waiting         <= 1'b0;
      pcm_channel_reset        <= CH_RST_INIT;
      compressed_channel_reset <= CH_RST_INIT;
      rdata                    <= BYTE_ZERO;
      data_oe                  <= 1'b0;
    end else if (CLK_EN) begin
      inbound_byte             <= next_inbound_byte;
      outbound_byte            <= next_outbound_byte;
      inbound_pending          <= next_inbound_pending;
      outbound_waiting         <= next_outbound_waiting;
      pcm_channel_reset        <= next_pcm_channel_reset;
      compressed_channel_reset <= next_compressed_channel_reset;
      rdata                    <= next_rdata;
      data_oe                  <= next_data_oe;
    end
  end

  // ****************************************************************
  // Audio input buffers
  // ****************************************************************
  // [RQ13] PCM select pushes
  assign pcm_if.push       = (access == ACC_WRITE) && (HOST_ADDR == SEL_PCM);
  // [RQ14] compressed select pushes
  assign cmp_if.push       = (access == ACC_WRITE) && (HOST_ADDR == SEL_COMPRESSED);
  assign pcm_if.push_data  = HOST_WDATA;
  assign cmp_if.push_data  = HOST_WDATA;
  assign pcm_if.chan_reset = pcm_channel_reset;
  assign cmp_if.chan_reset = compressed_channel_reset;
  assign pcm_if.pop        = PCM_POP && PCM_VALID;
  assign cmp_if.pop        = CMP_POP && CMP_VALID;

  audio_input_fifo u_pcm_fifo (.CLOCK(CLOCK), .RST_B(RST_B), .CLK_EN(CLK_EN), .f(pcm_if));
  audio_input_fifo u_cmp_fifo (.CLOCK(CLOCK), .RST_B(RST_B), .CLK_EN(CLK_EN), .f(cmp_if));

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      PCM_BYTE  <= BYTE_ZERO;
      PCM_VALID <= 1'b0;
      CMP_BYTE  <= BYTE_ZERO;
      CMP_VALID <= 1'b0;
    end else if (CLK_EN) begin
      PCM_BYTE  <= pcm_if.pop_data;
      PCM_VALID <= pcm_if.not_empty && !pcm_if.pop && !pcm_channel_reset;
      CMP_BYTE  <= cmp_if.pop_data;
      CMP_VALID <= cmp_if.not_empty && !cmp_if.pop && !compressed_channel_reset;
    end
  end

  assign HOST_RDATA             = rdata;
  assign HOST_DATA_OE           = data_oe;
  // [RQ16] attention mirrors waiting
  assign HOST_ATTENTION_REQUEST = outbound_waiting;
  assign CORE_MSG_RDATA         = inbound_byte;
  assign CORE_INBOUND_PENDING   = inbound_pending;
  assign CORE_OUTBOUND_WAITING  = outbound_waiting;
  assign PCM_CHANNEL_RESET      = pcm_channel_reset;
  assign CMP_CHANNEL_RESET      = compressed_channel_reset;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);

  pend_set_a: assert property (CLK_EN && host_wr_msg |=> inbound_pending) // [RQ9]
    else $error("inbound pending not set by host write");
  pend_clr_a: assert property (CLK_EN && CORE_MSG_RD && !host_wr_msg |=> !inbound_pending) // [RQ9]
    else $error("inbound pending not cleared by core read");
  wait_set_a: assert property (CLK_EN && core_wr_ok |=> outbound_waiting) // [RQ11]
    else $error("outbound waiting not set");
  wait_clr_a: assert property (CLK_EN && host_rd_msg && !core_wr_ok |=> !outbound_waiting) // [RQ11]
    else $error("outbound waiting not cleared by host read");
  attn_mirror_a: assert property (CLK_EN && (core_wr_ok || host_rd_msg) // [RQ16]
                                  |=> HOST_ATTENTION_REQUEST == $past(core_wr_ok))
    else $error("attention differs from outbound waiting");
  out_hold_a: assert property (outbound_waiting && CORE_MSG_WR |=> $stable(outbound_byte)) // [RQ12]
    else $error("outbound byte overwritten while waiting");
  msg_split_a: assert property (CLK_EN && host_wr_msg |=> $stable(outbound_byte) || $past(core_wr_ok)) // [RQ1]
    else $error("host write disturbed outbound byte");
  rst_zero_a: assert property (CLK_EN && HOST_RD && !HOST_WR && HOST_ADDR == SEL_CONTROL // [RQ18]
                               |=> HOST_RDATA[BIT_CMP_RST] == 1'b0 && HOST_RDATA[BIT_PCM_RST] == 1'b0)
    else $error("reset bits did not read zero");
  cmp_rst_a: assert property (CLK_EN && host_wr_ctl |=> CMP_CHANNEL_RESET == $past(HOST_WDATA[BIT_CMP_RST])) // [RQ4]
    else $error("compressed reset bit not taken");
  pcm_rst_a: assert property (CLK_EN && PCM_CHANNEL_RESET |=> !PCM_VALID) // [RQ19]
    else $error("PCM data offered during channel reset");
  pcm_flag_a: assert property (CLK_EN && HOST_RD && !HOST_WR && HOST_ADDR == SEL_CONTROL // [RQ7]
                               |=> HOST_RDATA[BIT_PCM_AF] == $past(pcm_if.almost_full))
    else $error("PCM almost full misreported");
  cmp_flag_a: assert property (CLK_EN && HOST_RD && !HOST_WR && HOST_ADDR == SEL_CONTROL // [RQ8]
                               |=> HOST_RDATA[BIT_CMP_AF] == $past(cmp_if.almost_full))
    else $error("compressed almost full misreported");
  pcm_push_a: assert property (CLK_EN && pcm_if.push && !PCM_CHANNEL_RESET // [RQ13]
                               |=> pcm_if.not_empty)
    else $error("PCM byte not taken into buffer");

  msg_round_c: cover property (host_wr_msg ##[1:8] CORE_MSG_RD);
  out_round_c: cover property (core_wr_ok ##[1:8] host_rd_msg);
  pcm_full_c:  cover property (pcm_if.almost_full);
  cmp_full_c:  cover property (cmp_if.almost_full);
endmodule // parallel_host_register_bank

// [bench/host_bus_model.sv]
// Host microcontroller model that drives the parallel register port.
`timescale 1ns/1ns
module host_bus_model
  import host_port_pkg::*;
(
  // Clock.
  input  wire logic       CLOCK,
  // Host bus.
  output logic      [1:0] HOST_ADDR,
  output logic            HOST_RD,
  output logic            HOST_WR,
  output logic      [7:0] HOST_WDATA,
  input  wire logic [7:0] HOST_RDATA,
  input  wire logic       HOST_DATA_OE
);
  initial begin
    HOST_ADDR  = SEL_MESSAGE;
    HOST_RD    = 1'b0;
    HOST_WR    = 1'b0;
    HOST_WDATA = BYTE_ZERO;
  end
  task automatic write_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    #1;
    HOST_ADDR  = a;
    HOST_WDATA = (a == SEL_CONTROL) ? (d & 8'h7E) : d;
    HOST_WR    = 1'b1;
    @(posedge CLOCK);
    #1;
    HOST_WR    = 1'b0;
    HOST_WDATA = ~HOST_WDATA;
  endtask
  task automatic read_reg(input logic [1:0] a, output logic [7:0] d, output logic oe);
    @(posedge CLOCK);
    #1;
    HOST_ADDR = {1'b0, a[0]};
    HOST_RD   = 1'b1;
    @(posedge CLOCK);
    #1;
    HOST_RD = 1'b0;
    d       = HOST_RDATA;
    oe      = HOST_DATA_OE;
  endtask
endmodule // host_bus_model

// [bench/testbench.sv]
// Self-checking testbench for the parallel host register bank.
`timescale 1ns/1ns
module testbench
  import host_port_pkg::*;
;
  logic       clock, rst_b, rd, wr, oe, attn, roe, clk_en;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, core_wdata, core_rdata, pcm_byte, cmp_byte, rv;
  logic       core_rd, core_wr, in_pend, out_wait, pcm_pop, cmp_pop;
  logic       pcm_valid, cmp_valid, pcm_rst, cmp_rst;
  int         err_count, num_checks, cycles, i, ch;

  host_bus_model i_host (.CLOCK(clock), .HOST_ADDR(addr), .HOST_RD(rd), .HOST_WR(wr),
    .HOST_WDATA(wdata), .HOST_RDATA(rdata), .HOST_DATA_OE(oe));

  parallel_host_register_bank i_dut (.CLOCK(clock), .RST_B(rst_b), .CLK_EN(clk_en),
    .HOST_ADDR(addr), .HOST_RD(rd), .HOST_WR(wr), .HOST_WDATA(wdata),
    .HOST_RDATA(rdata), .HOST_DATA_OE(oe), .HOST_ATTENTION_REQUEST(attn),
    .CORE_MSG_RD(core_rd), .CORE_MSG_WR(core_wr), .CORE_MSG_WDATA(core_wdata),
    .CORE_MSG_RDATA(core_rdata), .CORE_INBOUND_PENDING(in_pend),
    .CORE_OUTBOUND_WAITING(out_wait), .PCM_POP(pcm_pop), .CMP_POP(cmp_pop),
    .PCM_BYTE(pcm_byte), .PCM_VALID(pcm_valid), .CMP_BYTE(cmp_byte),
    .CMP_VALID(cmp_valid), .PCM_CHANNEL_RESET(pcm_rst), .CMP_CHANNEL_RESET(cmp_rst));

  always #25 clock = ~clock;

  // ****************************************************************
  // Helper tasks
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    if (err_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      wrap_up();
    end
  end

  // Core side pulse: 0 message read, 1 message write, 2 PCM pop, 3 compressed pop.
  task automatic core_pulse(input int k, input logic [7:0] d);
    @(posedge clock);
    #1;
    core_rd    = (k == 0);
    core_wr    = (k == 1);
    core_wdata = d;
    pcm_pop    = (k == 2);
    cmp_pop    = (k == 3);
    @(posedge clock);
    #1;
    {core_rd, core_wr, pcm_pop, cmp_pop} = 4'h0;
  endtask

  task automatic pop_check(input int c, input logic [7:0] exp);
    for (int w = 0; w < 8 && (c ? cmp_valid : pcm_valid) !== 1'b1; w++) begin
      @(posedge clock);
      #1;
    end
    check({7'h0, c ? cmp_valid : pcm_valid}, 8'h01);
    check(c ? cmp_byte : pcm_byte, exp);
    core_pulse(2 + c, BYTE_ZERO);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    clock = 1'b0;
    rst_b = 1'b0;
    clk_en = 1'b1;
    {core_rd, core_wr, pcm_pop, cmp_pop} = 4'h0;
    core_wdata = BYTE_ZERO;
    err_count  = 0;
    num_checks = 0;
    cycles     = 0;
    repeat (3) @(posedge clock);
    #1;
    rst_b = 1'b1;
    check({6'h0, pcm_rst, cmp_rst}, 8'h03);
    i_host.read_reg(SEL_CONTROL, rv, roe);
    check(rv, 8'h00);
    check({7'h0, roe}, 8'h01);
    i_host.write_reg(SEL_CONTROL, 8'h40);
    check({7'h0, oe}, 8'h00);
    check({6'h0, pcm_rst, cmp_rst}, 8'h01);
    i_host.write_reg(SEL_CONTROL, 8'h20);
    check({6'h0, pcm_rst, cmp_rst}, 8'h02);
    i_host.write_reg(SEL_CONTROL, 8'h00);
    check({6'h0, pcm_rst, cmp_rst}, 8'h00);
    // Inbound byte and its pending flag.
    i_host.write_reg(SEL_MESSAGE, 8'hA5);
    check(core_rdata, 8'hA5);
    i_host.read_reg(SEL_CONTROL, rv, roe);
    check(rv, 8'h04);
    core_pulse(0, BYTE_ZERO);
    check({7'h0, in_pend}, 8'h00);
    // Outbound byte, a dropped second write, and a crossing host write.
    core_pulse(1, 8'h3C);
    check({6'h0, attn, out_wait}, 8'h03);
    core_pulse(1, 8'hC3);
    i_host.write_reg(SEL_MESSAGE, 8'h77);
    i_host.read_reg(SEL_MESSAGE, rv, roe);
    check(rv, 8'h3C);
    check({7'h0, roe}, 8'h01);
    check({6'h0, attn, out_wait}, 8'h00);
    check(core_rdata, 8'h77);
    core_pulse(0, BYTE_ZERO);
    // With the clock enable low a message write must leave all state frozen.
    clk_en = 1'b0;
    i_host.write_reg(SEL_MESSAGE, 8'h5A);
    check({7'h0, in_pend}, 8'h00);
    check(core_rdata, 8'h77);
    clk_en = 1'b1;
    i_host.write_reg(SEL_CONTROL, 8'h1E);
    i_host.read_reg(SEL_CONTROL, rv, roe);
    check(rv, 8'h00);
    // Fill each buffer to the threshold, drain part, then reset the channel.
    for (ch = 0; ch < 2; ch++) begin
      for (i = 1; i <= 12; i++) begin
        i_host.write_reg(ch ? SEL_COMPRESSED : SEL_PCM, 8'(i));
        i_host.read_reg(SEL_CONTROL, rv, roe);
        check(rv, {3'h0, ch == 0 && i >= int'(AF_THRESHOLD),
                   ch == 1 && i >= int'(AF_THRESHOLD), 3'h0});
      end
      for (i = 1; i <= 4; i++) begin
        pop_check(ch, 8'(i));
      end
      i_host.write_reg(ch ? SEL_COMPRESSED : SEL_PCM, 8'h0D);
      i_host.write_reg(ch ? SEL_COMPRESSED : SEL_PCM, 8'h0E);
      i_host.write_reg(ch ? SEL_COMPRESSED : SEL_PCM, 8'h0F);
      i_host.write_reg(ch ? SEL_COMPRESSED : SEL_PCM, 8'h10);
      i_host.read_reg(SEL_CONTROL, rv, roe);
      check(rv, ch ? 8'h08 : 8'h10);
      i_host.write_reg(SEL_CONTROL, ch ? 8'h40 : 8'h20);
      check({7'h0, ch ? cmp_rst : pcm_rst}, 8'h01);
      i_host.write_reg(ch ? SEL_COMPRESSED : SEL_PCM, 8'h99);
      i_host.read_reg(SEL_CONTROL, rv, roe);
      check(rv, 8'h00);
      check({7'h0, ch ? cmp_valid : pcm_valid}, 8'h00);
      i_host.write_reg(SEL_CONTROL, 8'h00);
      i_host.write_reg(ch ? SEL_COMPRESSED : SEL_PCM, 8'hE0 + 8'(ch));
      pop_check(ch, 8'hE0 + 8'(ch));
    end
    wrap_up();
  end
endmodule // testbench
